// ---- hdl/eepc_pkg.sv ----
// Constants for the byte-wide erasable memory programming controller.
// Assumes a 200 MHz system clock; all device timings become cycle counts.
package eepc_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int CLK_MHZ = 200;
	// Times in nanoseconds as the device states them.
	localparam int T_ADDR_SU_NS = 200;
	localparam int T_ACCESS_NS = 650;
	localparam int T_CE_HIGH_NS = 1100;
	localparam int T_VPP_SU_NS = 5000;
	localparam int T_HOLD_NS = 200;
	localparam int T_PULSE_NS = 1000000;
	localparam int T_PULSE_MIN_NS = 500000;
	localparam int T_PULSE_MAX_NS = 10000000;
	localparam int CYC_ADDR_SU = (T_ADDR_SU_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_ACCESS = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_CE_HIGH = (T_CE_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_VPP_SU = (T_VPP_SU_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_HOLD = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_PULSE = (T_PULSE_NS / 1000) * CLK_MHZ;
	localparam int CYC_PULSE_MIN = (T_PULSE_MIN_NS / 1000) * CLK_MHZ;
	localparam int CYC_PULSE_MAX = (T_PULSE_MAX_NS / 1000) * CLK_MHZ;
	localparam int CNT_W = 24;
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_ERASE = 2'h1;
	localparam logic [1:0] OP_PROG = 2'h2;
	localparam logic [1:0] OP_NONE = 2'h3;
	typedef enum logic [3:0] {
		EEPC_IDLE, EEPC_RD_SU, EEPC_RD_WAIT, EEPC_VPP_UP,
		EEPC_PR_SU, EEPC_PULSE, EEPC_PR_HOLD, EEPC_VPP_DN, EEPC_REST
	} eepc_state_t;
endpackage

// ---- hdl/eepc_ctrl.sv ----
// Controller that drives an asynchronous byte-wide erasable memory pins.
// Assumes an external switch raises the supply on vpp_en and that the
// pin inputs from the memory arrive unsynchronised.
// Notes on behaviour
// - With the high supply on, a low output-enable pulse erases the array.
// - With the high supply on, a low chip-enable pulse programs one byte.
// - Each erase and each byte program lasts cmd_pulse cycles clamped to the strobe limits, or PULSE_CYC cycles (about one millisecond by default) when it is zero.
// - Reads are only made with the supply at its normal level.
// - The program strobe stays low between half a millisecond and ten; a zero cmd_pulse takes PULSE_CYC, which is not clamped.
// - The pulse length is chosen per command through cmd_pulse.
// - Address is valid at chip enable fall, data valid while it is low.
`timescale 1ns/1ps
`default_nettype none
module eepc_ctrl #(
	parameter int PULSE_CYC = eepc_pkg::CYC_PULSE
) (
	// Clock, reset and enable.
	input  wire logic                            clk,
	input  wire logic                            srst,
	input  wire logic                            ce,
	// User command port.
	input  wire logic                            cmd_valid,
	input  wire logic [1:0]                      cmd_op,
	input  wire logic [eepc_pkg::ADDR_W-1:0]     cmd_addr,
	input  wire logic [eepc_pkg::DATA_W-1:0]     cmd_data,
	input  wire logic [eepc_pkg::CNT_W-1:0]      cmd_pulse,
	output logic                                 cmd_ready,
	output logic                                 rd_valid,
	output logic [eepc_pkg::DATA_W-1:0]          rd_data,
	// Memory pins.
	output logic [eepc_pkg::ADDR_W-1:0]          mem_addr,
	output logic                                 mem_ce_n,
	output logic                                 mem_oe_n,
	output logic                                 mem_cs,
	output logic                                 vpp_en,
	input  wire logic [eepc_pkg::DATA_W-1:0]     mem_dq_in,
	output logic [eepc_pkg::DATA_W-1:0]          mem_dq_out,
	output logic                                 mem_dq_oe
);
	eepc_pkg::eepc_state_t state_reg, state_next;
	logic [eepc_pkg::CNT_W-1:0]  cnt_reg, cnt_next, pulse_reg, pulse_next;
	logic [1:0]                  op_reg, op_next;
	logic [eepc_pkg::ADDR_W-1:0] addr_reg, addr_next;
	logic [eepc_pkg::DATA_W-1:0] wdat_reg, wdat_next, rdat_reg, rdat_next;
	logic                        ce_n_reg, ce_n_next, oe_n_reg, oe_n_next;
	logic                        cs_reg, cs_next, vpp_reg, vpp_next;
	logic                        dqoe_reg, dqoe_next, rdv_reg, rdv_next;
	logic                        rdy_reg, rdy_next;
	logic [eepc_pkg::DATA_W-1:0] dq_s1_reg, dq_s2_reg;
	logic [eepc_pkg::CNT_W-1:0]  cmd_len;

	// Bus data comes from another chip, so it passes two flip-flops first.
	always_ff @(posedge clk) begin
		if (srst) begin
			dq_s1_reg <= 8'h00;
			dq_s2_reg <= 8'h00;
		end else if (ce) begin
			dq_s1_reg <= mem_dq_in;
			dq_s2_reg <= dq_s1_reg;
		end
	end

	// A zero length selects the nominal pulse; others are clamped to limits.
	always_comb begin
		cmd_len = cmd_pulse;
		if (cmd_pulse == '0)
			cmd_len = PULSE_CYC[eepc_pkg::CNT_W-1:0];
		else if (cmd_pulse < eepc_pkg::CYC_PULSE_MIN[eepc_pkg::CNT_W-1:0])
			cmd_len = eepc_pkg::CYC_PULSE_MIN[eepc_pkg::CNT_W-1:0];
		else if (cmd_pulse > eepc_pkg::CYC_PULSE_MAX[eepc_pkg::CNT_W-1:0])
			cmd_len = eepc_pkg::CYC_PULSE_MAX[eepc_pkg::CNT_W-1:0];
	end

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		pulse_next = pulse_reg;
		op_next = op_reg;
		addr_next = addr_reg;
		wdat_next = wdat_reg;
		rdat_next = rdat_reg;
		ce_n_next = ce_n_reg;
		oe_n_next = oe_n_reg;
		cs_next = cs_reg;
		vpp_next = vpp_reg;
		dqoe_next = dqoe_reg;
		rdv_next = 1'b0;
		rdy_next = rdy_reg;
		if (cnt_reg != '0)
			cnt_next = cnt_reg - 1'b1;
		case (state_reg)
			eepc_pkg::EEPC_IDLE: begin
				if (cmd_valid && rdy_reg && cmd_op != eepc_pkg::OP_NONE) begin
					rdy_next = 1'b0;
					op_next = cmd_op;
					addr_next = cmd_addr;
					wdat_next = cmd_data;
					pulse_next = cmd_len;
					if (cmd_op == eepc_pkg::OP_READ) begin
						cs_next = 1'b1;
						cnt_next = eepc_pkg::CYC_ADDR_SU[eepc_pkg::CNT_W-1:0];
						state_next = eepc_pkg::EEPC_RD_SU;
					end else begin
						// High supply only with both strobes high.
						vpp_next = 1'b1;
						cs_next = 1'b0;
						cnt_next = eepc_pkg::CYC_VPP_SU[eepc_pkg::CNT_W-1:0];
						state_next = eepc_pkg::EEPC_VPP_UP;
					end
				end
			end
			eepc_pkg::EEPC_RD_SU: begin
				if (cnt_reg == '0) begin
					ce_n_next = 1'b0;
					oe_n_next = 1'b0;
					cnt_next = eepc_pkg::CYC_ACCESS[eepc_pkg::CNT_W-1:0];
					state_next = eepc_pkg::EEPC_RD_WAIT;
				end
			end
			eepc_pkg::EEPC_RD_WAIT: begin
				// Latched data is sampled on the same edge as chip enable rises.
				if (cnt_reg == '0) begin
					rdat_next = dq_s2_reg;
					rdv_next = 1'b1;
					ce_n_next = 1'b1;
					oe_n_next = 1'b1;
					cs_next = 1'b0;
					cnt_next = eepc_pkg::CYC_CE_HIGH[eepc_pkg::CNT_W-1:0];
					state_next = eepc_pkg::EEPC_REST;
				end
			end
			eepc_pkg::EEPC_VPP_UP: begin
				if (cnt_reg == '0) begin
					if (op_reg == eepc_pkg::OP_PROG) begin
						dqoe_next = 1'b1;
						cnt_next = eepc_pkg::CYC_ADDR_SU[eepc_pkg::CNT_W-1:0];
						state_next = eepc_pkg::EEPC_PR_SU;
					end else begin
						oe_n_next = 1'b0;
						cnt_next = pulse_reg;
						state_next = eepc_pkg::EEPC_PULSE;
					end
				end
			end
			eepc_pkg::EEPC_PR_SU: begin
				if (cnt_reg == '0) begin
					ce_n_next = 1'b0;
					cnt_next = pulse_reg;
					state_next = eepc_pkg::EEPC_PULSE;
				end
			end
			eepc_pkg::EEPC_PULSE: begin
				if (cnt_reg == '0) begin
					ce_n_next = 1'b1;
					oe_n_next = 1'b1;
					cnt_next = eepc_pkg::CYC_HOLD[eepc_pkg::CNT_W-1:0];
					state_next = eepc_pkg::EEPC_PR_HOLD;
				end
			end
			eepc_pkg::EEPC_PR_HOLD: begin
				if (cnt_reg == '0) begin
					dqoe_next = 1'b0;
					vpp_next = 1'b0;
					cnt_next = eepc_pkg::CYC_VPP_SU[eepc_pkg::CNT_W-1:0];
					state_next = eepc_pkg::EEPC_VPP_DN;
				end
			end
			eepc_pkg::EEPC_VPP_DN: begin
				if (cnt_reg == '0) begin
					cnt_next = eepc_pkg::CYC_CE_HIGH[eepc_pkg::CNT_W-1:0];
					state_next = eepc_pkg::EEPC_REST;
				end
			end
			eepc_pkg::EEPC_REST: begin
				if (cnt_reg == '0) begin
					rdy_next = 1'b1;
					state_next = eepc_pkg::EEPC_IDLE;
				end
			end
			default: begin
				state_next = eepc_pkg::EEPC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= eepc_pkg::EEPC_IDLE;
			cnt_reg <= '0;
			pulse_reg <= '0;
			op_reg <= eepc_pkg::OP_NONE;
			addr_reg <= 10'h000;
			wdat_reg <= 8'h00;
			rdat_reg <= 8'h00;
			ce_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			cs_reg <= 1'b0;
			vpp_reg <= 1'b0;
			dqoe_reg <= 1'b0;
			rdv_reg <= 1'b0;
			rdy_reg <= 1'b1;
		end else if (ce) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			pulse_reg <= pulse_next;
			op_reg <= op_next;
			addr_reg <= addr_next;
			wdat_reg <= wdat_next;
			rdat_reg <= rdat_next;
			ce_n_reg <= ce_n_next;
			oe_n_reg <= oe_n_next;
			cs_reg <= cs_next;
			vpp_reg <= vpp_next;
			dqoe_reg <= dqoe_next;
			rdv_reg <= rdv_next;
			rdy_reg <= rdy_next;
		end
	end

	assign cmd_ready = rdy_reg;
	assign rd_valid = rdv_reg;
	assign rd_data = rdat_reg;
	assign mem_addr = addr_reg;
	assign mem_ce_n = ce_n_reg;
	assign mem_oe_n = oe_n_reg;
	assign mem_cs = cs_reg;
	assign vpp_en = vpp_reg;
	assign mem_dq_out = wdat_reg;
	assign mem_dq_oe = dqoe_reg;

	no_dual_low_a: assert property (
		@(posedge clk) disable iff (srst)
		vpp_reg |-> (ce_n_reg || oe_n_reg))
		else $error("both strobes low at high supply");
	no_read_hv_a: assert property (
		@(posedge clk) disable iff (srst)
		(!oe_n_reg && cs_reg) |-> !vpp_reg)
		else $error("read strobe at high supply");
	ce_fall_addr_a: assert property (
		@(posedge clk) disable iff (srst)
		$fell(ce_n_reg) |-> $stable(addr_reg))
		else $error("address moved at chip enable fall");
	prog_data_a: assert property (
		@(posedge clk) disable iff (srst)
		(vpp_reg && !ce_n_reg) |-> (dqoe_reg && $stable(wdat_reg)))
		else $error("write data not held during strobe");
	pulse_vpp_a: assert property (
		@(posedge clk) disable iff (srst)
		($fell(ce_n_reg) && vpp_reg) |-> $past(vpp_reg, 2))
		else $error("program strobe without supply settled");
	erase_vpp_a: assert property (
		@(posedge clk) disable iff (srst)
		($fell(oe_n_reg) && vpp_reg) |-> $past(vpp_reg, 2))
		else $error("erase strobe without supply settled");
	pulse_len_a: assert property (
		@(posedge clk) disable iff (srst || !ce)
		(state_reg == eepc_pkg::EEPC_PULSE) |-> (cnt_reg <= pulse_reg))
		else $error("pulse counter beyond chosen length");
	// Only the nominal length may lie outside the strobe limits.
	pulse_range_a: assert property (
		@(posedge clk) disable iff (srst)
		(state_reg == eepc_pkg::EEPC_PULSE) |->
		(pulse_reg == PULSE_CYC[eepc_pkg::CNT_W-1:0] ||
		(pulse_reg >= eepc_pkg::CYC_PULSE_MIN[eepc_pkg::CNT_W-1:0] &&
		pulse_reg <= eepc_pkg::CYC_PULSE_MAX[eepc_pkg::CNT_W-1:0])))
		else $error("pulse length outside strobe limits");
	rd_done_a: assert property (
		@(posedge clk) disable iff (srst)
		rdv_reg |-> (ce_n_reg && !vpp_reg))
		else $error("read result while strobe still low");
	cv_read_c: cover property (@(posedge clk) disable iff (srst) rdv_reg);
	cv_erase_c: cover property (@(posedge clk) disable iff (srst)
		vpp_reg && !oe_n_reg);
	cv_prog_c: cover property (@(posedge clk) disable iff (srst)
		vpp_reg && !ce_n_reg);
endmodule
`default_nettype wire

// ---- test/eepc_mem_model.sv ----
// Behavioural model of the erasable byte-wide memory facing the controller.
// Assumes the supply level arrives as vpp and the bus is resolved outside.
`timescale 1ns/1ps
`default_nettype none
module eepc_mem_model (
	// Memory pins.
	input  wire logic                        vpp,
	input  wire logic                        ce_n,
	input  wire logic                        oe_n,
	input  wire logic                        cs,
	input  wire logic [eepc_pkg::ADDR_W-1:0] addr,
	input  wire logic [eepc_pkg::DATA_W-1:0] dq_i,
	output logic      [eepc_pkg::DATA_W-1:0] dq_o,
	output logic                             dq_drv,
	// Protocol watch.
	output logic                             bad
);
	logic [7:0] mem [0:1023];
	logic [9:0] lat_a;
	logic [7:0] lat_d;
	logic [7:0] w_d;
	logic [7:0] last;
	initial begin
		bad = 1'b0;
		last = 8'h00;
		for (int i = 0; i < 1024; i++) mem[i] = i[7:0] ^ 8'h5A;
	end
	always @(negedge ce_n) begin
		lat_a = addr;
		lat_d = mem[addr];
		w_d = dq_i;
		if (vpp && !oe_n) bad = 1'b1;
	end
	always @(negedge oe_n) if (vpp && !ce_n) bad = 1'b1;
	always @(posedge oe_n) if (vpp)
		for (int i = 0; i < 1024; i++) mem[i] = 8'h00;
	always @(posedge ce_n) if (vpp) begin
		if (dq_i !== w_d) bad = 1'b1;
		mem[lat_a] = mem[lat_a] | dq_i;
	end
	assign dq_drv = !ce_n && !oe_n && cs && !vpp;
	// A released bus shows the inverse of its last value, never a held copy.
	always @(dq_drv, lat_d) begin
		if (dq_drv) begin
			last = lat_d;
			dq_o = lat_d;
		end else dq_o = ~last;
	end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the erasable memory controller.
// Assumes eepc_mem_model on the pins and a short program pulse parameter.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic       clk, srst, cmd_valid, cmd_ready, rd_valid, ce_en;
	logic [23:0] cmd_pulse;
	logic       mem_ce_n, mem_oe_n, mem_cs, vpp_en, mem_dq_oe, dq_drv, bad;
	logic [1:0] cmd_op;
	logic [9:0] cmd_addr, mem_addr;
	logic [7:0] cmd_data, rd_data, mem_dq_in, mem_dq_out, dq_o, got;
	int         n_mismatch, cmp_count, cyc;
	initial clk = 1'b0;
	always #2.5 clk = ~clk;
	eepc_ctrl #(.PULSE_CYC(50)) uut (.clk(clk), .srst(srst), .ce(ce_en),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.cmd_data(cmd_data), .cmd_pulse(cmd_pulse), .cmd_ready(cmd_ready),
		.rd_valid(rd_valid), .rd_data(rd_data), .mem_addr(mem_addr),
		.mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n), .mem_cs(mem_cs),
		.vpp_en(vpp_en), .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out),
		.mem_dq_oe(mem_dq_oe));
	eepc_mem_model mdl (.vpp(vpp_en), .ce_n(mem_ce_n), .oe_n(mem_oe_n),
		.cs(mem_cs), .addr(mem_addr), .dq_i(mem_dq_in), .dq_o(dq_o),
		.dq_drv(dq_drv), .bad(bad));
	assign mem_dq_in = (mem_dq_oe && !dq_drv) ? mem_dq_out : dq_o;
	task automatic check(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			$display("wrong value %0t got %h expected %h", $time, g, e);
			n_mismatch++;
		end
	endtask
	task automatic run(input logic [1:0] op, input logic [9:0] a,
		input logic [7:0] d);
		@(posedge clk);
		#1 cmd_valid = 1'b1;
		cmd_op = op;
		cmd_addr = a;
		cmd_data = d;
		@(posedge clk);
		#1 cmd_valid = 1'b0;
		wait_done;
	endtask
	// Waits for the controller to come back, keeping any read result.
	task automatic wait_done;
		got = 8'hXX;
		for (int i = 0; i < 4000 && !cmd_ready; i++) begin
			if (rd_valid === 1'b1) got = rd_data;
			@(posedge clk);
			#1;
		end
		check({7'h00, cmd_ready}, 8'h01);
	endtask
	task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
		run(2'h0, a, 8'h00);
		check(got, e);
	endtask
	task automatic t_idle;
		check({mem_ce_n, mem_oe_n, mem_cs, vpp_en}, 8'h0C);
		check({mem_dq_oe, cmd_ready, rd_valid}, 8'h02);
	endtask
	// A read is frozen by the clock enable well past its normal end.
	task automatic t_freeze;
		@(posedge clk);
		#1 cmd_valid = 1'b1;
		cmd_op = 2'h0;
		cmd_addr = 10'h003;
		@(posedge clk);
		#1 cmd_valid = 1'b0;
		repeat (60) @(posedge clk);
		#1 check({mem_ce_n, mem_oe_n, mem_cs}, 8'h01);
		ce_en = 1'b0;
		repeat (200) @(posedge clk);
		#1 check({mem_ce_n, mem_oe_n, mem_cs, cmd_ready}, 8'h02);
		ce_en = 1'b1;
		wait_done;
		check(got, 8'h59);
	endtask
	// A too short requested pulse must be stretched to the lower limit.
	// The erase is then cut by a reset, which also checks recovery.
	task automatic t_clamp;
		@(posedge clk);
		#1 cmd_valid = 1'b1;
		cmd_op = 2'h1;
		cmd_pulse = 24'h000001;
		@(posedge clk);
		#1 cmd_valid = 1'b0;
		cmd_pulse = 24'h000000;
		repeat (3000) @(posedge clk);
		#1 check({7'h00, mem_oe_n}, 8'h00);
		srst = 1'b1;
		repeat (20) @(posedge clk);
		#1 srst = 1'b0;
		t_idle;
	endtask
	task automatic t_read;
		rd_chk(10'h003, 8'h59);
		rd_chk(10'h3FF, 8'hA5);
	endtask
	task automatic t_refuse;
		@(posedge clk);
		#1 cmd_valid = 1'b1;
		cmd_op = 2'h3;
		repeat (3) @(posedge clk);
		#1 cmd_valid = 1'b0;
		check({mem_ce_n, vpp_en, cmd_ready}, 8'h05);
	endtask
	task automatic t_erase;
		run(2'h1, 10'h000, 8'h00);
		rd_chk(10'h000, 8'h00);
		rd_chk(10'h3FF, 8'h00);
	endtask
	task automatic t_prog;
		run(2'h2, 10'h005, 8'hA5);
		rd_chk(10'h005, 8'hA5);
		run(2'h2, 10'h005, 8'h5A);
		rd_chk(10'h005, 8'hFF);
		run(2'h2, 10'h3FF, 8'h3C);
		rd_chk(10'h3FF, 8'h3C);
		check({7'h00, bad}, 8'h00);
	endtask
	task automatic print_verdict;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// The ceiling leaves room for sixteen erase or program commands.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			print_verdict;
		end
	end
	initial begin
		{srst, cmd_valid, cmd_op, cmd_addr, cmd_data} = {1'b1, 21'h000000};
		{n_mismatch, cmp_count, cyc} = '0;
		cmd_pulse = 24'h000000;
		ce_en = 1'b1;
		repeat (20) @(posedge clk);
		#1 srst = 1'b0;
		t_idle;
		t_read;
		t_freeze;
		t_refuse;
		t_clamp;
		t_erase;
		t_prog;
		print_verdict;
	end
endmodule
`default_nettype wire
